// file: pwm_sync_clear_ctrl.sv
`timescale 1ns/1ps
module pwm_sync_clear_ctrl (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic inTb2,
    input wire logic suppressWindow,
    input wire logic initPeriod,
    input wire logic tb1End,
    input wire logic tb2End,
    input wire logic skipWindow,
    input wire logic [5:0] pwmRaw,
    input wire logic hallInputA,
    input wire logic hallInputB,
    input wire logic hallInputC,
    output logic [5:0] pwmOut,
    output logic counterClear,
    output logic transferPulse,
    output logic [1:0] counterRun,
    pwm_sync_if.dev link
);
    logic [15:0] waveCtl_r;
    logic [15:0] outCtl_r;
    logic [15:0] gateCtl_r;
    logic [15:0] modeCtl_r;
    logic [15:0] skipCtl_r;
    logic [1:0] start_r;
    logic suppressed_r;
    logic forced_r;
    logic clrIn_r;
    logic holdInit_r;
    logic [2:0] hall_r;
    logic clrPulse;
    logic running;
    logic accept;
    logic forceInit;
    logic [2:0] phase;
    logic [5:0] drive;
    logic [5:0] initLevels;
    logic posLevel;
    logic negLevel;
    logic [3:0] xferMode;
    logic [1:0] linkMode;
    logic crestOk;
    logic troughOk;
    logic [15:0] status;

    function automatic logic wr(input logic [2:0] idx);
        wr = link.regWrite && link.regAddr == idx;
    endfunction : wr

    assign running = start_r[pwm_sync_pkg::START_CH3] &&
        start_r[pwm_sync_pkg::START_CH4];
    assign posLevel = outCtl_r[pwm_sync_pkg::OUT_POS];
    assign negLevel = outCtl_r[pwm_sync_pkg::OUT_NEG];
    assign initLevels = outCtl_r[pwm_sync_pkg::OUT_INIT_LO +: 6];
    assign xferMode = modeCtl_r[pwm_sync_pkg::MODE_LO +: 4];
    assign linkMode = modeCtl_r[pwm_sync_pkg::LINK_LO +: 2];

    // Registers; writing during counting is allowed, old value rules
    // for a clear in the same cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            waveCtl_r <= pwm_sync_pkg::RST_ZERO;
            outCtl_r <= pwm_sync_pkg::RST_ZERO;
            gateCtl_r <= pwm_sync_pkg::RST_ZERO;
            modeCtl_r <= pwm_sync_pkg::RST_ZERO;
            skipCtl_r <= pwm_sync_pkg::RST_ZERO;
            start_r <= 2'h0;
        end else if (ce) begin
            if (wr(pwm_sync_pkg::DEV_WAVE)) begin
                waveCtl_r <= link.regWdata;
            end
            if (wr(pwm_sync_pkg::DEV_OUTCTL)) begin
                outCtl_r <= link.regWdata;
            end
            if (wr(pwm_sync_pkg::DEV_GATE)) begin
                gateCtl_r <= link.regWdata;
            end
            if (wr(pwm_sync_pkg::DEV_MODE)) begin
                modeCtl_r <= link.regWdata;
            end
            if (wr(pwm_sync_pkg::DEV_SKIP)) begin
                skipCtl_r <= link.regWdata;
            end
            if (wr(pwm_sync_pkg::DEV_START)) begin
                start_r <= link.regWdata[1:0];
            end
        end
    end

    // Level input from the primary unit turned into one-cycle pulse
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            clrIn_r <= 1'b0;
        end else if (ce) begin
            clrIn_r <= link.syncClear;
        end
    end
    assign clrPulse = link.syncClear && !clrIn_r;

    assign accept = clrPulse && running &&
        !(waveCtl_r[pwm_sync_pkg::WAVE_SUPP] && suppressWindow);
    // Start-up initial period always wins over Tb2 suppression
    assign forceInit = accept && (initPeriod || !inTb2 ||
        !waveCtl_r[pwm_sync_pkg::WAVE_INIT_SUPP]);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            counterClear <= 1'b0;
            holdInit_r <= 1'b0;
        end else if (ce) begin
            counterClear <= accept;
            if (forceInit) begin
                holdInit_r <= 1'b1;
            end else if (initPeriod || !running) begin
                holdInit_r <= 1'b0;
            end
        end
    end

    // Sticky status, hardware set beats software clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            suppressed_r <= 1'b0;
            forced_r <= 1'b0;
        end else if (ce) begin
            if (clrPulse && running && !accept) begin
                suppressed_r <= 1'b1;
            end else if (wr(pwm_sync_pkg::DEV_STATUS) &&
                    link.regWdata[pwm_sync_pkg::STAT_SUPPRESSED]) begin
                suppressed_r <= 1'b0;
            end
            if (forceInit) begin
                forced_r <= 1'b1;
            end else if (wr(pwm_sync_pkg::DEV_STATUS) &&
                    link.regWdata[pwm_sync_pkg::STAT_FORCED]) begin
                forced_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hall_r <= 3'h0;
        end else if (ce) begin
            hall_r <= {hallInputC, hallInputB, hallInputA};
        end
    end

    always_comb begin
        if (gateCtl_r[pwm_sync_pkg::GATE_FEEDBACK]) begin
            phase = {gateCtl_r[pwm_sync_pkg::GATE_W],
                gateCtl_r[pwm_sync_pkg::GATE_V],
                gateCtl_r[pwm_sync_pkg::GATE_U]};
        end else begin
            phase = hall_r;
        end
    end

    // Output pairs: 0/1 U, 2/3 V, 4/5 W; even positive, odd negative
    always_comb begin
        drive = 6'h00;
        for (int i = 0; i < 3; i++) begin
            logic on_p;
            logic on_n;
            on_p = phase[i] && !phase[(i + 2) % 3];
            on_n = !phase[i] && phase[(i + 2) % 3];
            if (gateCtl_r[pwm_sync_pkg::GATE_BRUSHLESS]) begin
                if (gateCtl_r[pwm_sync_pkg::GATE_P]) begin
                    on_p = on_p && pwmRaw[2 * i];
                end
                if (gateCtl_r[pwm_sync_pkg::GATE_N]) begin
                    on_n = on_n && pwmRaw[2 * i + 1];
                end
            end else begin
                on_p = pwmRaw[2 * i];
                on_n = pwmRaw[2 * i + 1];
            end
            drive[2 * i] = on_p ? posLevel : !posLevel;
            drive[2 * i + 1] = on_n ? negLevel : !negLevel;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pwmOut <= pwm_sync_pkg::RST_LEVELS;
        end else if (ce) begin
            if (forceInit || holdInit_r || initPeriod || !running) begin
                pwmOut <= initLevels;
            end else begin
                pwmOut <= drive;
            end
        end
    end

    always_comb begin
        crestOk = linkMode != pwm_sync_pkg::LINK_SKIP ||
            (skipCtl_r[pwm_sync_pkg::SKIP_CREST] && skipWindow);
        troughOk = linkMode != pwm_sync_pkg::LINK_SKIP ||
            (skipCtl_r[pwm_sync_pkg::SKIP_TROUGH] && skipWindow);
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            transferPulse <= 1'b0;
        end else if (ce) begin
            transferPulse <= running && ((tb1End && crestOk &&
                (xferMode == pwm_sync_pkg::XFER_CREST ||
                 xferMode == pwm_sync_pkg::XFER_BOTH)) ||
                (tb2End && troughOk &&
                 xferMode == pwm_sync_pkg::XFER_BOTH));
        end
    end

    always_comb begin
        status = 16'h0000;
        status[pwm_sync_pkg::STAT_RUN] = running;
        status[pwm_sync_pkg::STAT_SUPPRESSED] = suppressed_r;
        status[pwm_sync_pkg::STAT_FORCED] = forced_r;
    end

    // Read data follows the last written address
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link.regRdata <= 16'h0000;
            link.devRunning <= 1'b0;
            counterRun <= 2'h0;
        end else if (ce) begin
            link.devRunning <= running;
            counterRun <= start_r;
            unique case (link.regAddr)
                pwm_sync_pkg::DEV_WAVE: link.regRdata <= waveCtl_r;
                pwm_sync_pkg::DEV_OUTCTL: link.regRdata <= outCtl_r;
                pwm_sync_pkg::DEV_GATE: link.regRdata <= gateCtl_r;
                pwm_sync_pkg::DEV_MODE: link.regRdata <= modeCtl_r;
                pwm_sync_pkg::DEV_SKIP: link.regRdata <= skipCtl_r;
                pwm_sync_pkg::DEV_START: link.regRdata <= {14'h0, start_r};
                pwm_sync_pkg::DEV_STATUS: link.regRdata <= status;
                default: link.regRdata <= 16'h0000;
            endcase
        end
    end
endmodule : pwm_sync_clear_ctrl

// file: pwm_sync_pkg.sv
package pwm_sync_pkg;
    // Device register indices on the carrier
    localparam int DEV_AW = 3;
    localparam int DEV_DW = 16;
    localparam logic [2:0] DEV_WAVE = 3'h0;
    localparam logic [2:0] DEV_OUTCTL = 3'h1;
    localparam logic [2:0] DEV_GATE = 3'h2;
    localparam logic [2:0] DEV_MODE = 3'h3;
    localparam logic [2:0] DEV_SKIP = 3'h4;
    localparam logic [2:0] DEV_START = 3'h5;
    localparam logic [2:0] DEV_STATUS = 3'h6;
    // Waveform control fields
    localparam int WAVE_CLR_EN = 0;
    localparam int WAVE_INIT_SUPP = 1;
    localparam int WAVE_SUPP = 7;
    // Output control fields
    localparam int OUT_POS = 0;
    localparam int OUT_NEG = 1;
    localparam int OUT_INIT_LO = 2;
    // Gate control fields
    localparam int GATE_U = 0;
    localparam int GATE_V = 1;
    localparam int GATE_W = 2;
    localparam int GATE_FEEDBACK = 3;
    localparam int GATE_P = 4;
    localparam int GATE_N = 5;
    localparam int GATE_BRUSHLESS = 6;
    // Mode fields
    localparam int MODE_LO = 0;
    localparam int LINK_LO = 4;
    localparam logic [3:0] XFER_CREST = 4'hD;
    localparam logic [3:0] XFER_BOTH = 4'hF;
    localparam logic [1:0] LINK_SKIP = 2'h2;
    // Skip, start and status fields
    localparam int SKIP_CREST = 0;
    localparam int SKIP_TROUGH = 1;
    localparam int START_CH3 = 0;
    localparam int START_CH4 = 1;
    localparam int STAT_RUN = 0;
    localparam int STAT_SUPPRESSED = 1;
    localparam int STAT_FORCED = 2;
    // Reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [5:0] RST_LEVELS = 6'h00;
    // Host APB map
    localparam logic [7:0] APB_START = 8'h00;
    localparam logic [7:0] APB_CLRSRC = 8'h04;
    localparam logic [7:0] APB_DEVCMD = 8'h08;
    localparam logic [7:0] APB_DEVRD = 8'h0C;
    localparam logic [7:0] APB_CMP0 = 8'h10;
    localparam logic [7:0] APB_CNT0 = 8'h20;
    localparam int CLR_SEL_LO = 0;
    localparam int CLR_EN = 2;
    localparam int CMD_ADDR_LO = 16;
    localparam int NUM_PRI_CH = 3;
endpackage : pwm_sync_pkg

// file: pwm_sync_if.sv
`timescale 1ns/1ps
interface pwm_sync_if;
    logic syncClear;
    logic [2:0] regAddr;
    logic [15:0] regWdata;
    logic regWrite;
    logic [15:0] regRdata;
    logic devRunning;
    modport dev (
        input syncClear, regAddr, regWdata, regWrite,
        output regRdata, devRunning
    );
    modport pri (
        output syncClear, regAddr, regWdata, regWrite,
        input regRdata, devRunning
    );
endinterface : pwm_sync_if

// file: pwm_primary_unit.sv
`timescale 1ns/1ps
module pwm_primary_unit #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    pwm_sync_if.pri link
);
    logic [2:0] runBits_r;
    logic [2:0] clrSrc_r;
    logic [CNT_W-1:0] cmp_r [pwm_sync_pkg::NUM_PRI_CH];
    logic [CNT_W-1:0] cnt_r [pwm_sync_pkg::NUM_PRI_CH];
    logic [2:0] match;
    logic setup;
    logic wrEn;
    logic hit;
    logic [31:0] rdVal;

    assign setup = psel && !penable && !pready;
    assign wrEn = psel && penable && pready && pwrite;

    always_comb begin
        hit = 1'b1;
        rdVal = 32'h00000000;
        unique case (paddr)
            pwm_sync_pkg::APB_START: rdVal = {29'h0, runBits_r};
            pwm_sync_pkg::APB_CLRSRC: rdVal = {29'h0, clrSrc_r};
            pwm_sync_pkg::APB_DEVCMD: rdVal = {13'h0, link.regAddr,
                link.regWdata};
            pwm_sync_pkg::APB_DEVRD: rdVal = {15'h0, link.devRunning,
                link.regRdata};
            pwm_sync_pkg::APB_CMP0: rdVal = 32'(cmp_r[0]);
            pwm_sync_pkg::APB_CMP0 + 8'h04: rdVal = 32'(cmp_r[1]);
            pwm_sync_pkg::APB_CMP0 + 8'h08: rdVal = 32'(cmp_r[2]);
            pwm_sync_pkg::APB_CNT0: rdVal = 32'(cnt_r[0]);
            pwm_sync_pkg::APB_CNT0 + 8'h04: rdVal = 32'(cnt_r[1]);
            pwm_sync_pkg::APB_CNT0 + 8'h08: rdVal = 32'(cnt_r[2]);
            default: hit = 1'b0;
        endcase
    end

    // One wait-free access phase: answer is ready the cycle after setup
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && !hit;
            prdata <= (setup && !pwrite) ? rdVal : 32'h00000000;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            runBits_r <= 3'h0;
            clrSrc_r <= 3'h0;
            for (int i = 0; i < pwm_sync_pkg::NUM_PRI_CH; i++) begin
                cmp_r[i] <= CNT_W'(pwm_sync_pkg::RST_ZERO);
            end
        end else if (ce && wrEn) begin
            unique case (paddr)
                pwm_sync_pkg::APB_START: runBits_r <= pwdata[2:0];
                pwm_sync_pkg::APB_CLRSRC: clrSrc_r <= pwdata[2:0];
                pwm_sync_pkg::APB_CMP0: cmp_r[0] <= pwdata[CNT_W-1:0];
                pwm_sync_pkg::APB_CMP0 + 8'h04: cmp_r[1] <= pwdata[CNT_W-1:0];
                pwm_sync_pkg::APB_CMP0 + 8'h08: cmp_r[2] <= pwdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Forwarded device register writes, one-cycle strobe
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link.regWrite <= 1'b0;
            link.regAddr <= 3'h0;
            link.regWdata <= 16'h0000;
        end else if (ce) begin
            link.regWrite <= wrEn && paddr == pwm_sync_pkg::APB_DEVCMD;
            if (wrEn && paddr == pwm_sync_pkg::APB_DEVCMD) begin
                link.regAddr <= pwdata[pwm_sync_pkg::CMD_ADDR_LO +: 3];
                link.regWdata <= pwdata[15:0];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < pwm_sync_pkg::NUM_PRI_CH; i++) begin
            match[i] = runBits_r[i] && cnt_r[i] == cmp_r[i];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < pwm_sync_pkg::NUM_PRI_CH; i++) begin
                cnt_r[i] <= CNT_W'(pwm_sync_pkg::RST_ZERO);
            end
        end else if (ce) begin
            for (int i = 0; i < pwm_sync_pkg::NUM_PRI_CH; i++) begin
                if (match[i]) begin
                    cnt_r[i] <= CNT_W'(pwm_sync_pkg::RST_ZERO);
                end else if (runBits_r[i]) begin
                    cnt_r[i] <= cnt_r[i] + CNT_W'(1);
                end
            end
        end
    end

    // Selected channel's compare match becomes the cross-unit clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link.syncClear <= 1'b0;
        end else if (ce) begin
            link.syncClear <= clrSrc_r[pwm_sync_pkg::CLR_EN] &&
                clrSrc_r[1:0] < 2'h3 && match[clrSrc_r[1:0]];
        end
    end
endmodule : pwm_primary_unit

// file: pwm_sync_properties.sv
`timescale 1ns/1ps
module pwm_sync_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic syncClear,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic devRunning,
    input wire logic inTb2,
    input wire logic suppressWindow,
    input wire logic initPeriod,
    input wire logic tb1End,
    input wire logic tb2End,
    input wire logic skipWindow,
    input wire logic [5:0] pwmOut,
    input wire logic counterClear,
    input wire logic transferPulse
);
    logic suppBit_r;
    logic [5:0] initLv_r;
    logic [5:0] mode_r;
    logic run_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Mirror of device fields, updated by the same strobe
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            suppBit_r <= 1'b0;
            initLv_r <= 6'h00;
            mode_r <= 6'h00;
            run_r <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == pwm_sync_pkg::DEV_START) begin
                run_r <= regWdata[pwm_sync_pkg::START_CH3] &&
                    regWdata[pwm_sync_pkg::START_CH4];
            end
            if (regAddr == pwm_sync_pkg::DEV_WAVE) begin
                suppBit_r <= regWdata[pwm_sync_pkg::WAVE_SUPP];
            end
            if (regAddr == pwm_sync_pkg::DEV_OUTCTL) begin
                initLv_r <= regWdata[7:2];
            end
            if (regAddr == pwm_sync_pkg::DEV_MODE) begin
                mode_r <= regWdata[5:0];
            end
        end
    end
    a_run_mirror: assert property (devRunning == $past(run_r))
        else $error("run status wrong");
    a_clear_taken: assert property ($rose(syncClear) && run_r
        && !(suppBit_r && suppressWindow)
        |=> counterClear) else $error("accepted clear lost");
    a_clear_blocked: assert property ($rose(syncClear) && suppBit_r
        && suppressWindow |=> !counterClear) else $error("clear not held");
    a_clear_single: assert property (counterClear |=> !counterClear)
        else $error("clear pulse too long");
    a_clear_cause: assert property (counterClear |-> $past(syncClear))
        else $error("clear without request");
    a_init_outside: assert property (counterClear && !$past(inTb2)
        |-> pwmOut == $past(initLv_r)) else $error("initial levels missing");
    a_init_start: assert property (counterClear && $past(initPeriod)
        |-> pwmOut == $past(initLv_r)) else $error("start initial missing");
    a_xfer_crest: assert property (tb1End && run_r
        && mode_r[5:4] != pwm_sync_pkg::LINK_SKIP
        && (mode_r[3:0] == pwm_sync_pkg::XFER_CREST
        || mode_r[3:0] == pwm_sync_pkg::XFER_BOTH)
        |=> transferPulse) else $error("crest transfer missing");
    a_xfer_trough: assert property (tb2End && !tb1End
        && mode_r[3:0] == pwm_sync_pkg::XFER_CREST |=> !transferPulse)
        else $error("trough transfer in crest mode");
    a_xfer_skip: assert property (transferPulse
        && mode_r[5:4] == pwm_sync_pkg::LINK_SKIP |-> $past(skipWindow))
        else $error("transfer outside skip period");
    cover property ($rose(syncClear) ##1 counterClear);
    cover property ($rose(syncClear) && suppBit_r && suppressWindow);
    cover property (transferPulse && mode_r[5:4] == pwm_sync_pkg::LINK_SKIP);
endmodule : pwm_sync_properties

// file: tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic inTb2, suppressWindow, initPeriod, tb1End, tb2End, skipWindow;
    logic hallInputA, hallInputB, hallInputC, counterClear, transferPulse;
    logic [5:0] pwmRaw, pwmOut;
    logic [1:0] counterRun;
    int errorCnt = 0;
    int samplesChecked = 0;
    int cycles = 0;
    localparam int LIMIT = 20000;
    pwm_sync_if link ();
    pwm_primary_unit #(.CNT_W(4)) i_pwm_primary_unit (.mclk, .reset,
        .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .link(link));
    pwm_sync_clear_ctrl i_pwm_sync_clear_ctrl (.mclk, .reset, .ce(1'b1),
        .inTb2, .suppressWindow, .initPeriod, .tb1End, .tb2End,
        .skipWindow, .pwmRaw, .hallInputA, .hallInputB, .hallInputC,
        .pwmOut, .counterClear, .transferPulse, .counterRun, .link(link));
    pwm_sync_properties i_pwm_sync_properties (.mclk, .reset,
        .syncClear(link.syncClear), .regAddr(link.regAddr),
        .regWdata(link.regWdata), .regWrite(link.regWrite),
        .devRunning(link.devRunning), .inTb2, .suppressWindow, .initPeriod,
        .tb1End, .tb2End, .skipWindow, .pwmOut, .counterClear,
        .transferPulse);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Slave may add wait states; only the timeout ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic dev_wr(input logic [2:0] idx, input logic [15:0] d);
        apb(1'b1, pwm_sync_pkg::APB_DEVCMD, {13'h0000, idx, d}, rd, err);
        repeat (3) @(posedge mclk);
    endtask : dev_wr
    task automatic dev_rd(input logic [2:0] idx, input logic [15:0] d);
        dev_wr(idx, d);
        apb(1'b0, pwm_sync_pkg::APB_DEVRD, 32'h00000000, rd, err);
    endtask : dev_rd
    task automatic clear_case(input logic t2, input logic ip,
        input logic sw, input logic [2:0] expStat);
        @(posedge mclk);
        inTb2 <= t2;
        initPeriod <= ip;
        suppressWindow <= sw;
        dev_wr(pwm_sync_pkg::DEV_STATUS, 16'h0006);
        forever begin
            @(negedge mclk);
            if (link.syncClear === 1'b1) break;
        end
        repeat (4) @(posedge mclk);
        dev_rd(pwm_sync_pkg::DEV_STATUS, 16'h0000);
        check({29'h00000000, rd[2:0]}, {29'h00000000, expStat});
        $display("test clear %b%b%b done", t2, ip, sw);
    endtask : clear_case
    task automatic xfer(input logic e1, input logic e2, input logic x);
        @(posedge mclk);
        tb1End <= e1;
        tb2End <= e2;
        @(posedge mclk);
        tb1End <= 1'b0;
        tb2End <= 1'b0;
        #1;
        check({31'h00000000, transferPulse}, {31'h00000000, x});
    endtask : xfer
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errorCnt++;
            print_verdict;
        end
    end
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = 43'h00000000000;
        {inTb2, suppressWindow, initPeriod, tb1End, tb2End} = 5'h00;
        skipWindow = 1'b0;
        pwmRaw = 6'h15;
        {hallInputA, hallInputB, hallInputC} = 3'h5;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        check({26'h0000000, pwmOut}, 32'h00000000);
        apb(1'b0, 8'hFC, 32'h00000000, rd, err);
        check({31'h00000000, err}, 32'h00000001);
        check(rd, 32'h00000000);
        $display("test reset and map done");
        dev_wr(pwm_sync_pkg::DEV_START, 16'h0000);
        apb(1'b1, pwm_sync_pkg::APB_START, 32'h00000000, rd, err);
        dev_wr(pwm_sync_pkg::DEV_OUTCTL, 16'h00AB);
        dev_wr(pwm_sync_pkg::DEV_WAVE, 16'h0002);
        dev_wr(pwm_sync_pkg::DEV_START, 16'h0003);
        #1;
        check({30'h00000000, counterRun}, 32'h00000003);
        apb(1'b1, pwm_sync_pkg::APB_CLRSRC, 32'h00000004, rd, err);
        apb(1'b1, pwm_sync_pkg::APB_CMP0, 32'h00000003, rd, err);
        apb(1'b1, pwm_sync_pkg::APB_START, 32'h00000001, rd, err);
        apb(1'b0, pwm_sync_pkg::APB_START, 32'h00000000, rd, err);
        check(rd, 32'h00000001);
        clear_case(1'b0, 1'b0, 1'b0, 3'h5);
        clear_case(1'b1, 1'b0, 1'b0, 3'h1);
        clear_case(1'b1, 1'b1, 1'b0, 3'h5);
        dev_rd(pwm_sync_pkg::DEV_WAVE, 16'h0002);
        check({16'h0000, rd[15:0]}, 32'h00000002);
        dev_wr(pwm_sync_pkg::DEV_WAVE, rd[15:0] | 16'h0080);
        clear_case(1'b0, 1'b0, 1'b1, 3'h3);
        clear_case(1'b0, 1'b0, 1'b0, 3'h5);
        dev_wr(pwm_sync_pkg::DEV_WAVE, 16'h0002);
        dev_wr(pwm_sync_pkg::DEV_MODE, 16'h000D);
        xfer(1'b1, 1'b0, 1'b1);
        xfer(1'b0, 1'b1, 1'b0);
        dev_wr(pwm_sync_pkg::DEV_MODE, 16'h000F);
        xfer(1'b0, 1'b1, 1'b1);
        xfer(1'b1, 1'b0, 1'b1);
        dev_wr(pwm_sync_pkg::DEV_MODE, 16'h002D);
        dev_wr(pwm_sync_pkg::DEV_SKIP, 16'h0001);
        xfer(1'b1, 1'b0, 1'b0);
        @(posedge mclk);
        skipWindow <= 1'b1;
        xfer(1'b1, 1'b0, 1'b1);
        $display("test transfer done");
        apb(1'b1, pwm_sync_pkg::APB_START, 32'h00000000, rd, err);
        @(posedge mclk);
        initPeriod <= 1'b1;
        @(posedge mclk);
        initPeriod <= 1'b0;
        dev_wr(pwm_sync_pkg::DEV_GATE, 16'h0049);
        #1;
        check({26'h0000000, pwmOut}, 32'h00000009);
        dev_wr(pwm_sync_pkg::DEV_GATE, 16'h0040);
        #1;
        check({26'h0000000, pwmOut}, 32'h00000018);
        dev_wr(pwm_sync_pkg::DEV_OUTCTL, 16'h00A8);
        #1;
        check({26'h0000000, pwmOut}, 32'h00000027);
        $display("test phase outputs done");
        dev_wr(pwm_sync_pkg::DEV_START, 16'h0000);
        #1;
        check({30'h00000000, counterRun}, 32'h00000000);
        print_verdict;
    end
endmodule : tb
